// ==== core/tapid_fsm.sv ====
// sixteen-state test access port controller, stepped by a rising test clock strobe
`timescale 1ns/1ps
module tapid_fsm (
  input wire logic clk,
  input wire logic reset,
  input wire logic step,
  input wire logic mode,
  output tapid_pkg::tapid_state_e state
);
  import tapid_pkg::*;
  tapid_state_e next_state;
  always_comb begin
    next_state = state;
    case (state)
      tapid_reset: next_state = mode ? tapid_reset : tapid_idle;
      tapid_idle: next_state = mode ? tapid_sel_dr : tapid_idle;
      tapid_sel_dr: next_state = mode ? tapid_sel_ir : tapid_cap_dr;
      tapid_cap_dr: next_state = mode ? tapid_ex1_dr : tapid_sh_dr;
      tapid_sh_dr: next_state = mode ? tapid_ex1_dr : tapid_sh_dr;
      tapid_ex1_dr: next_state = mode ? tapid_upd_dr : tapid_pause_dr;
      tapid_pause_dr: next_state = mode ? tapid_ex2_dr : tapid_pause_dr;
      tapid_ex2_dr: next_state = mode ? tapid_upd_dr : tapid_sh_dr;
      tapid_upd_dr: next_state = mode ? tapid_sel_dr : tapid_idle;
      tapid_sel_ir: next_state = mode ? tapid_reset : tapid_cap_ir;
      tapid_cap_ir: next_state = mode ? tapid_ex1_ir : tapid_sh_ir;
      tapid_sh_ir: next_state = mode ? tapid_ex1_ir : tapid_sh_ir;
      tapid_ex1_ir: next_state = mode ? tapid_upd_ir : tapid_pause_ir;
      tapid_pause_ir: next_state = mode ? tapid_ex2_ir : tapid_pause_ir;
      tapid_ex2_ir: next_state = mode ? tapid_upd_ir : tapid_sh_ir;
      tapid_upd_ir: next_state = mode ? tapid_sel_dr : tapid_idle;
      default: next_state = tapid_reset;
    endcase
  end
  // the sequence always reaches reset after five high mode samples
  always_ff @(posedge clk) begin
    if (reset) begin
      state <= tapid_reset;
    end else if (step) begin
      state <= next_state;
    end
  end
endmodule

// ==== core/tapid_params.svh ====
// timing counts, codes and field positions of the scan port instruction decode
`ifndef TAPID_PARAMS_SVH
`define TAPID_PARAMS_SVH
`define TAPID_IR_WIDTH 3
`define TAPID_IR_CAPTURE 3'h1
`define TAPID_OP_EXTEST 3'h0
`define TAPID_OP_IDCODE 3'h1
`define TAPID_OP_SAMPLEZ 3'h2
`define TAPID_OP_SAMPLE 3'h4
`define TAPID_OP_BYPASS 3'h7
`define TAPID_ID_WIDTH 32
// arbitrary neutral identity value; bit 0 set as the id format expects
`define TAPID_ID_DEFAULT 32'h0000_0001
`define TAPID_RESET_ONES 5
`define TAPID_CLK_PERIOD_NS 25
`define TAPID_TCK_MIN_NS 50
`define TAPID_TCK_MIN_CYCLES ((`TAPID_TCK_MIN_NS + `TAPID_CLK_PERIOD_NS - 1) / `TAPID_CLK_PERIOD_NS)
`endif

// ==== core/tapid_pkg.sv ====
// types shared by the scan port instruction decode
package tapid_pkg;
  typedef enum logic [3:0] {
    tapid_reset, tapid_idle, tapid_sel_dr, tapid_cap_dr, tapid_sh_dr, tapid_ex1_dr,
    tapid_pause_dr, tapid_ex2_dr, tapid_upd_dr, tapid_sel_ir, tapid_cap_ir, tapid_sh_ir,
    tapid_ex1_ir, tapid_pause_ir, tapid_ex2_ir, tapid_upd_ir
  } tapid_state_e;
  typedef enum logic [1:0] {tapid_sel_bypass, tapid_sel_bsr, tapid_sel_id} tapid_dsel_e;
endpackage

// ==== core/tapid_sync.sv ====
// two flip-flop synchroniser for a bundle of pin levels
`timescale 1ns/1ps
module tapid_sync #(
  parameter int WIDTH = 3
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta;
  if (WIDTH < 1) begin : g_bad_width
    $error("tapid_sync: WIDTH must be positive");
  end
  // pins idle high through their pull-ups
  always_ff @(posedge clk) begin
    if (reset) begin
      meta <= '1;
      sync_out <= '1;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end
endmodule

// ==== core/tapid_top.sv ====
// boundary-scan instruction decode and data register selection
//
// Overview of operation
// - capture-ir loads 01 into low bits
// - shift-ir moves instruction between tdi and tdo
// - new instruction acts only at update-ir
// - code 111 selects the bypass flop
// - code 100 samples pins into scan chain
// - pinless chain cells capture fixed defaults
// - code 000 runs external test
// - external test leaves inputs wired to core
// - external test drives chain on outputs
// - external test capture loads pins in parallel
// - code 001 captures and shifts identity rom
// - identity instruction after power-up and reset
// - code 010 floats outputs, shifts chain
// - codes written msb left, lsb right
// - instruction register is three bits
// - bypass is one flop stage
// - five high mode edges reach reset
// - identity is 32 bits, lsb first
`timescale 1ns/1ps
`include "tapid_params.svh"
module tapid_top #(
  parameter int BSR_WIDTH = 8,
  parameter logic [BSR_WIDTH-1:0] PIN_MASK = 8'hF0,
  parameter logic [BSR_WIDTH-1:0] PAD_DEFAULT = '1,
  parameter logic [`TAPID_ID_WIDTH-1:0] ID_VALUE = `TAPID_ID_DEFAULT
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe,
  input wire logic [BSR_WIDTH-1:0] pin_level,
  output logic [BSR_WIDTH-1:0] pin_drive,
  output logic pin_test_mode,
  output logic pin_float,
  output logic [`TAPID_IR_WIDTH-1:0] active_instr
);
  import tapid_pkg::*;

  // a chain of no cells cannot sit between the serial pins
  if (BSR_WIDTH < 1) begin : g_bad_width
    $error("tapid_top: BSR_WIDTH must be positive");
  end

  // ----------------------------------------
  // pin sampling and test clock edges
  // ----------------------------------------
  // pin levels come from the memory's own clock domain, so they pass two flops first;
  // a level still moving at capture may land either way, hence the far-side hold window
  logic [BSR_WIDTH-1:0] pin_sync;
  logic [2:0] pins_sync;
  logic tck_d;
  tapid_sync #(.WIDTH(3)) u_sync (
    .clk(clk),
    .reset(reset),
    .async_in({tck, tms, tdi}),
    .sync_out(pins_sync)
  );
  tapid_sync #(.WIDTH(BSR_WIDTH)) u_pin_sync (
    .clk(clk),
    .reset(reset),
    .async_in(pin_level),
    .sync_out(pin_sync)
  );
  wire tck_s = pins_sync[2];
  wire tms_s = pins_sync[1];
  wire tdi_s = pins_sync[0];
  wire tck_rise = tck_s & ~tck_d;
  wire tck_fall = ~tck_s & tck_d;

  tapid_state_e state;
  tapid_fsm u_fsm (
    .clk(clk),
    .reset(reset),
    .step(tck_rise),
    .mode(tms_s),
    .state(state)
  );

  // ----------------------------------------
  // instruction register
  // ----------------------------------------
  logic [`TAPID_IR_WIDTH-1:0] ir_shift;
  logic [`TAPID_IR_WIDTH-1:0] ir_active;
  // msb on the left of each code
  wire in_cap_ir = state == tapid_cap_ir;
  wire in_sh_ir = state == tapid_sh_ir;
  wire in_upd_ir = state == tapid_upd_ir;
  wire in_cap_dr = state == tapid_cap_dr;
  wire in_sh_dr = state == tapid_sh_dr;
  wire in_reset = state == tapid_reset;

  // synchroniser leaves reset high, so one harmless fall is seen in test-logic-reset
  always_ff @(posedge clk) begin
    tck_d <= reset ? 1'b1 : tck_s;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ir_shift <= `TAPID_OP_IDCODE;
    end else if (tck_rise && in_cap_ir) begin
      ir_shift <= `TAPID_IR_CAPTURE;
    end else if (tck_rise && in_sh_ir) begin
      ir_shift <= {tdi_s, ir_shift[`TAPID_IR_WIDTH-1:1]};
    end
  end

  // update-ir is acted on at the falling edge inside that state
  always_ff @(posedge clk) begin
    if (reset) begin
      ir_active <= `TAPID_OP_IDCODE;
    end else if (in_reset) begin
      ir_active <= `TAPID_OP_IDCODE;
    end else if (tck_fall && in_upd_ir) begin
      ir_active <= ir_shift;
    end
  end

  // ----------------------------------------
  // instruction decode
  // ----------------------------------------
  wire op_extest = ir_active == `TAPID_OP_EXTEST;
  wire op_samplez = ir_active == `TAPID_OP_SAMPLEZ;
  wire op_sample = ir_active == `TAPID_OP_SAMPLE;
  wire op_idcode = ir_active == `TAPID_OP_IDCODE;
  wire use_bsr = op_extest | op_samplez | op_sample;
  // private and bypass codes fall through to bypass
  tapid_dsel_e dsel;
  assign dsel = use_bsr ? tapid_sel_bsr : (op_idcode ? tapid_sel_id : tapid_sel_bypass);

  // ----------------------------------------
  // data registers
  // ----------------------------------------
  logic bypass_bit;
  logic [`TAPID_ID_WIDTH-1:0] id_shift;
  logic [BSR_WIDTH-1:0] bsr_shift;
  logic [BSR_WIDTH-1:0] bsr_hold;
  logic [BSR_WIDTH-1:0] bsr_cap;

  genvar gi;
  generate
    for (gi = 0; gi < BSR_WIDTH; gi++) begin : g_cell
      assign bsr_cap[gi] = PIN_MASK[gi] ? pin_sync[gi] : PAD_DEFAULT[gi];
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (reset) begin
      bypass_bit <= 1'b0;
    end else if (tck_rise && in_cap_dr) begin
      bypass_bit <= 1'b0;
    end else if (tck_rise && in_sh_dr) begin
      bypass_bit <= tdi_s;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      id_shift <= '0;
    end else if (tck_rise && in_cap_dr && dsel == tapid_sel_id) begin
      id_shift <= ID_VALUE;
    end else if (tck_rise && in_sh_dr && dsel == tapid_sel_id) begin
      id_shift <= {tdi_s, id_shift[`TAPID_ID_WIDTH-1:1]};
    end
  end

  // pin ring captured on the rising edge for any chain instruction
  always_ff @(posedge clk) begin
    if (reset) begin
      bsr_shift <= '0;
    end else if (tck_rise && in_cap_dr && use_bsr) begin
      bsr_shift <= bsr_cap;
    end else if (tck_rise && in_sh_dr && use_bsr) begin
      bsr_shift <= {tdi_s, bsr_shift[BSR_WIDTH-1:1]};
    end
  end

  // holding stage feeds the output drivers; loaded at update falling edges
  always_ff @(posedge clk) begin
    if (reset) begin
      bsr_hold <= '0;
    end else if (tck_fall && (state == tapid_upd_dr) && use_bsr) begin
      bsr_hold <= bsr_shift;
    end
  end

  // ----------------------------------------
  // serial output, changes on falling edge
  // ----------------------------------------
  wire serial_bit = in_sh_ir ? ir_shift[0] :
                    (dsel == tapid_sel_bsr) ? bsr_shift[0] :
                    (dsel == tapid_sel_id) ? id_shift[0] : bypass_bit;
  wire shifting = in_sh_ir | in_sh_dr;

  always_ff @(posedge clk) begin
    if (reset) begin
      tdo <= 1'b0;
      tdo_oe <= 1'b0;
    end else if (tck_fall) begin
      tdo <= shifting ? serial_bit : 1'b0;
      tdo_oe <= shifting;
    end
  end

  // ----------------------------------------
  // pin control outputs
  // ----------------------------------------
  // functional inputs are never gated here, the core keeps seeing its pins
  wire ext_next = op_extest;
  always_ff @(posedge clk) begin
    if (reset) begin
      pin_test_mode <= 1'b0;
      pin_float <= 1'b0;
      pin_drive <= '0;
      active_instr <= `TAPID_OP_IDCODE;
    end else begin
      pin_test_mode <= ext_next;
      pin_float <= op_samplez;
      pin_drive <= bsr_hold;
      active_instr <= ir_active;
    end
  end

  // on entering external test, ext_load_pending marks the update-ir fall; the held chain keeps its last update-dr value
  logic ext_load_pending;
  always_ff @(posedge clk) begin
    if (reset) begin
      ext_load_pending <= 1'b0;
    end else begin
      ext_load_pending <= tck_fall && in_upd_ir && (ir_shift == `TAPID_OP_EXTEST);
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  chk_capture_ir_pattern: assert property (@(posedge clk) disable iff (reset)
    (tck_rise && in_cap_ir) |=> ir_shift[1:0] == 2'b01)
    else $error("capture-ir did not load 01");
  chk_ir_hold_until_update: assert property (@(posedge clk) disable iff (reset)
    (!in_reset && !(tck_fall && in_upd_ir)) |=> $stable(ir_active))
    else $error("instruction changed outside update-ir");
  chk_reset_idcode: assert property (@(posedge clk) disable iff (reset)
    in_reset |=> ir_active == `TAPID_OP_IDCODE)
    else $error("reset state did not restore identity instruction");
  chk_private_bypass: assert property (@(posedge clk) disable iff (reset)
    (ir_active == 3'h3 || ir_active == 3'h5 || ir_active == 3'h6 || ir_active == 3'h7)
      |-> dsel == tapid_sel_bypass)
    else $error("private code did not select bypass");
  chk_id_capture: assert property (@(posedge clk) disable iff (reset)
    (tck_rise && in_cap_dr && op_idcode) |=> id_shift == ID_VALUE)
    else $error("identity not captured");
  chk_bsr_capture: assert property (@(posedge clk) disable iff (reset)
    (tck_rise && in_cap_dr && use_bsr) |=> (bsr_shift & ~PIN_MASK) == (PAD_DEFAULT & ~PIN_MASK))
    else $error("pinless cells lost defaults");
  chk_float_samplez: assert property (@(posedge clk) disable iff (reset)
    op_samplez |=> pin_float)
    else $error("outputs not floated for sample-z");
  chk_extest_drive: assert property (@(posedge clk) disable iff (reset)
    ext_load_pending |=> ##1 pin_test_mode)
    else $error("external test did not drive outputs");
  chk_bypass_shift: assert property (@(posedge clk) disable iff (reset)
    (tck_rise && in_sh_dr) |=> bypass_bit == $past(tdi_s))
    else $error("bypass stage not single flop");
  chk_tmr_reset: assert property (@(posedge clk) disable iff (reset)
    (tck_rise && tms_s && state == tapid_sel_ir) |=> in_reset)
    else $error("controller missed reset path");
  chk_pin_capture: assert property (@(posedge clk) disable iff (reset)
    (tck_rise && in_cap_dr && use_bsr) |=>
      (bsr_shift & PIN_MASK) == ($past(pin_sync) & PIN_MASK))
    else $error("pin levels not captured into chain");
  chk_update_loads: assert property (@(posedge clk) disable iff (reset)
    (tck_fall && in_upd_ir) |=> ir_active == $past(ir_shift))
    else $error("update-ir did not load the new instruction");
  chk_active_instr: assert property (@(posedge clk) disable iff (reset)
    (active_instr != ir_active) |=> active_instr == $past(ir_active))
    else $error("active instruction output lags");
  chk_bypass_capture: assert property (@(posedge clk) disable iff (reset)
    (tck_rise && in_cap_dr) |=> !bypass_bit)
    else $error("bypass stage not cleared at capture");
  chk_id_shift: assert property (@(posedge clk) disable iff (reset)
    (tck_rise && in_sh_dr && op_idcode) |=> id_shift[30:0] == $past(id_shift[31:1]))
    else $error("identity not shifted lsb first");
  // serial output and pin control
  chk_tdo_oe_shift: assert property (@(posedge clk) disable iff (reset)
    (tck_fall && (in_sh_ir || in_sh_dr)) |=> tdo_oe)
    else $error("serial out not enabled while shifting");
  chk_tdo_quiet: assert property (@(posedge clk) disable iff (reset)
    (tck_fall && !in_sh_ir && !in_sh_dr) |=> (!tdo_oe && !tdo))
    else $error("serial out active outside shift");
  chk_test_mode_follow: assert property (@(posedge clk) disable iff (reset)
    (op_extest != pin_test_mode) |=> pin_test_mode == $past(op_extest))
    else $error("test mode does not follow code 000");
  chk_float_only: assert property (@(posedge clk) disable iff (reset)
    !op_samplez |=> !pin_float)
    else $error("outputs floated without sample-z");
  chk_drive_from_hold: assert property (@(posedge clk) disable iff (reset)
    (tck_fall && state == tapid_upd_dr && use_bsr) |=> ##1 pin_drive == $past(bsr_shift, 2))
    else $error("pin drive does not follow updated chain");
endmodule

// ==== tb/tapid_ctrl_model.sv ====
// board-side scan controller model driving the test pins
`timescale 1ns/1ps
module tapid_ctrl_model (
  input wire logic clk,
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo
);
  // --------------------------------------------------
  // one test clock period: 5 clk low, 3 clk high
  // --------------------------------------------------
  // tdo read just before the rise, the design answers within 4 clk of the fall
  // tck stands low between frames, tdi rests at its pull-up level
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end

  task automatic step(input logic m, input logic d, output logic q);
    @(negedge clk);
    tms = m;
    tdi = d;
    repeat (4) @(negedge clk);
    q = tdo;
    tck = 1'b1;
    repeat (3) @(negedge clk);
    tck = 1'b0;
  endtask

  task automatic reset_tap;
    logic q;
    repeat (5) step(1'b1, 1'b1, q);
  endtask

  task automatic to_idle;
    logic q;
    step(1'b0, 1'b1, q);
  endtask

  // --------------------------------------------------
  // frames, lsb first, starting in idle and ending in idle, except load_ir without upd, which stops in exit1-ir
  // --------------------------------------------------
  task automatic load_ir(input logic [2:0] code, output logic [2:0] cap, input bit upd);
    logic q;
    step(1'b1, 1'b1, q);
    step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
    step(1'b0, 1'b1, q);
    for (int i = 0; i < 3; i++) begin
      step(i == 2, code[i], cap[i]);
    end
    if (upd) begin
      step(1'b1, 1'b1, q);
      step(1'b0, 1'b1, q);
    end
    tdi = 1'b1;
  endtask

  task automatic shift_dr(input int n, input logic [31:0] din, output logic [31:0] dout);
    logic q;
    dout = '0;
    // memory inputs must already be steady here for the capture
    step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
    step(1'b0, 1'b1, q);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], dout[i]);
    end
    step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
    tdi = 1'b1;
  endtask
endmodule

// ==== tb/testbench.sv ====
// self-checking bench for the scan port instruction decode
`timescale 1ns/1ps
`include "tapid_params.svh"
module testbench;
  // arbitrary identity value, bit 0 set
  localparam logic [31:0] ID_VAL = 32'h1234_5679;
  localparam logic [7:0] MASK = 8'hF0;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic tck, tms, tdi, tdo, tdo_oe, pin_test_mode, pin_float;
  logic [7:0] pin_level = 8'h00;
  logic [7:0] pin_drive;
  logic [2:0] active_instr, cap;
  logic [31:0] d;
  int n_mismatch = 0;
  int compares = 0;

  always #12.5 clk = ~clk;

  tapid_top #(.BSR_WIDTH(8), .PIN_MASK(MASK), .PAD_DEFAULT(8'hFF), .ID_VALUE(ID_VAL)) dut (
    .clk(clk), .reset(reset), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
    .tdo_oe(tdo_oe), .pin_level(pin_level), .pin_drive(pin_drive),
    .pin_test_mode(pin_test_mode), .pin_float(pin_float), .active_instr(active_instr)
  );

  // a released serial out is not driven: the controller sees the opposite level
  tapid_ctrl_model ctl (.clk(clk), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo_oe ? tdo : ~tdo));

  // --------------------------------------------------
  // helpers
  // --------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic test_done;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic set_pins(input logic [7:0] v);
    @(negedge clk);
    pin_level = v; // only changed in idle, well clear of capture
  endtask

  // --------------------------------------------------
  // scenarios
  // --------------------------------------------------
  task automatic t_reset_id;
    chk(active_instr, `TAPID_OP_IDCODE, "instr after reset");
    chk({tdo_oe, pin_float, pin_test_mode}, 3'b000, "idle outputs after reset");
    ctl.to_idle;
    ctl.load_ir(`TAPID_OP_IDCODE, cap, 1'b1);
    chk(cap, 3'b001, "ir capture pattern");
    ctl.shift_dr(32, 32'hFFFF_FFFF, d);
    chk(d, ID_VAL, "identity shift");
  endtask

  task automatic t_hold_bypass;
    logic q;
    ctl.load_ir(`TAPID_OP_BYPASS, cap, 1'b0);
    chk(active_instr, `TAPID_OP_IDCODE, "instr before update");
    ctl.step(1'b1, 1'b1, q);
    ctl.step(1'b0, 1'b1, q);
    chk(active_instr, `TAPID_OP_BYPASS, "instr after update");
    ctl.shift_dr(3, 32'h0000_0003, d);
    chk(d[2:0], 3'b110, "bypass one stage delay");
    chk(tdo_oe, 1'b0, "serial out released after shift");
  endtask

  task automatic t_private;
    logic [2:0] codes [3] = '{3'h3, 3'h5, 3'h6};
    foreach (codes[i]) begin
      ctl.load_ir(codes[i], cap, 1'b1);
      chk(active_instr, codes[i], "private code held");
      chk({pin_float, pin_test_mode}, 2'b00, "private leaves pins");
      ctl.shift_dr(2, 32'h0000_0001, d);
      chk(d[1:0], 2'b10, "private acts as bypass");
    end
  endtask

  task automatic t_sample;
    set_pins(8'hA5);
    ctl.load_ir(`TAPID_OP_SAMPLE, cap, 1'b1);
    chk({pin_float, pin_test_mode}, 2'b00, "sample leaves pins");
    ctl.shift_dr(8, 32'h0000_003C, d);
    chk(d[7:0], 8'((8'hA5 & MASK) | ~MASK), "sample capture");
  endtask

  task automatic t_extest;
    ctl.load_ir(`TAPID_OP_EXTEST, cap, 1'b1);
    chk(pin_test_mode, 1'b1, "external test active");
    chk(pin_drive, 8'h3C, "preloaded chain on pins");
    set_pins(8'h5A);
    ctl.shift_dr(8, 32'h0000_0000, d);
    chk(d[7:0], 8'((8'h5A & MASK) | ~MASK), "external capture");
    chk(pin_drive, 8'h00, "pins follow new chain");
  endtask

  task automatic t_samplez;
    ctl.load_ir(`TAPID_OP_SAMPLEZ, cap, 1'b1);
    chk({pin_float, pin_test_mode}, 2'b10, "outputs floated");
    set_pins(8'hC3);
    ctl.shift_dr(8, 32'h0000_0000, d);
    chk(d[7:0], 8'((8'hC3 & MASK) | ~MASK), "float capture");
  endtask

  task automatic t_tap_reset;
    ctl.reset_tap;
    chk(active_instr, `TAPID_OP_IDCODE, "instr after mode reset");
    chk(pin_float, 1'b0, "float cleared by reset");
  endtask

  // --------------------------------------------------
  // main sequence and watchdog
  // --------------------------------------------------
  initial begin
    repeat (3) @(negedge clk);
    reset = 1'b0;
    repeat (3) @(negedge clk);
    t_reset_id;
    t_hold_bypass;
    t_private;
    t_sample;
    t_extest;
    t_samplez;
    t_tap_reset;
    test_done;
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    $display("MISMATCH %0t run did not finish", $time);
    test_done;
  end
endmodule
